/* bench/tb_timed_material_gating.sv */
/*
 bench for the gating pair: software side over AXI4-Lite, sensor side by pins.
 assumes a shortened tick so every interval but the gating timeout fits one run.
*/
`timescale 1ns/1ps
module tb_timed_material_gating;
	localparam int unsigned TICK = 2; // cycles per ms, shortened
	logic core_clk = 1'h0;
	logic rst_b = 1'h0;
	logic [2:0] mode = 3'h0;
	logic field = 1'h0;
	logic sync_a = 1'h0;
	logic sync_b = 1'h0;
	logic button = 1'h0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, outs, restart, override, act;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] err;
	int fail_count = 0;
	int check_count = 0;
	////////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;
	tmg_link_if u_tmg_link_if ();
	assign act = u_tmg_link_if.gating_active;
	tmg_gate_dev #(.TICK_CYCLES(TICK)) u_tmg_gate_dev (.CORE_CLK(core_clk), .RST_B(rst_b),
		.LINK(u_tmg_link_if), .MODE_SEL(mode), .FIELD_INTERRUPTED(field),
		.SYNC_A_BLOCKED(sync_a), .SYNC_B_BLOCKED(sync_b), .RESET_BUTTON(button),
		.SAFETY_SWITCH_OUTPUTS(outs), .ERROR_CODE(err), .RESTART_REQUIRED(restart),
		.OVERRIDE_REQUIRED(override));
	// byte strobes tied full: every write is a whole word
	tmg_gate_ctl u_tmg_gate_ctl (.CORE_CLK(core_clk), .RST_B(rst_b), .LINK(u_tmg_link_if),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	tmg_asserts #(.TICK_CYCLES(TICK)) u_tmg_asserts (.CORE_CLK(core_clk), .RST_B(rst_b),
		.gate_request(u_tmg_link_if.gate_request), .timeout_hold(u_tmg_link_if.timeout_hold),
		.gating_active(act), .MODE_SEL(mode), .FIELD_INTERRUPTED(field),
		.SYNC_A_BLOCKED(sync_a), .SYNC_B_BLOCKED(sync_b), .SAFETY_SWITCH_OUTPUTS(outs),
		.ERROR_CODE(err), .RESTART_REQUIRED(restart), .OVERRIDE_REQUIRED(override));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	task automatic wait_ms(input int ms);
		repeat (ms * TICK) @(posedge core_clk);
	endtask : wait_ms
	// write: each channel dropped once taken, hold bready until bvalid
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		check(bresp, r);
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		check(rdata, d);
		check(rresp, r);
	endtask : axi_read
	// control word, then time for link and sequencer to follow
	task automatic ctl(input logic [2:0] v);
		axi_write(tmg_pkg::CTRL_OFS, {29'h0000_0000, v}, tmg_pkg::RESP_OKAY);
		repeat (6) @(posedge core_clk);
	endtask : ctl
	task automatic press(input int ms);
		button <= 1'h1;
		wait_ms(ms);
		button <= 1'h0;
		wait_ms(5);
	endtask : press
	////////////////////////////////////////////////////////////////////////
	task automatic reg_test();
		axi_read(tmg_pkg::CTRL_OFS, 32'h0000_0000, tmg_pkg::RESP_OKAY);
		axi_write(4'h8, 32'h0000_0001, tmg_pkg::RESP_SLVERR);
		axi_read(4'hC, 32'h0000_0000, tmg_pkg::RESP_SLVERR);
		ctl(3'h2);
		axi_read(tmg_pkg::STAT_OFS, 32'h0000_0002, tmg_pkg::RESP_OKAY);
		ctl(3'h0);
	endtask : reg_test
	task automatic off_mode_test();
		field <= 1'h1;
		ctl(3'h1);
		wait_ms(10);
		check(act, 1'h0);
		check(outs, 1'h0);
		field <= 1'h0;
		ctl(3'h0);
		wait_ms(200);
	endtask : off_mode_test
	task automatic fast_test();
		mode <= tmg_pkg::FAST_CONVEYOR_MODE;
		ctl(3'h1);
		check(act, 1'h1);
		check(u_tmg_link_if.timeout_hold, 1'h0);
		field <= 1'h1;
		wait_ms(50);
		field <= 1'h0;
		wait_ms(900);
		check(act, 1'h1);
		wait_ms(200);
		check(act, 1'h0);
		ctl(3'h0);
		wait_ms(200);
		ctl(3'h1);
		field <= 1'h1;
		wait_ms(50);
		field <= 1'h0;
		ctl(3'h0);
		wait_ms(50);
		check(act, 1'h1);
		wait_ms(100);
		check(act, 1'h0);
	endtask : fast_test
	task automatic gate_low_test();
		ctl(3'h1);
		field <= 1'h1;
		wait_ms(20);
		ctl(3'h0);
		wait_ms(3800);
		check(act, 1'h1);
		check(outs, 1'h1);
		wait_ms(300);
		check(act, 1'h0);
		check(outs, 1'h0);
		ctl(3'h1);
		check(restart, 1'h1);
		sync_a <= 1'h1;
		sync_b <= 1'h1;
		wait_ms(5);
		check(override, 1'h1);
		sync_a <= 1'h0;
		sync_b <= 1'h0;
		wait_ms(5);
		press(100);
		check(act, 1'h0);
		press(200);
		check(act, 1'h1);
		field <= 1'h0;
		ctl(3'h0);
		wait_ms(200);
	endtask : gate_low_test
	task automatic lockout_test();
		ctl(3'h1);
		wait_ms(3900);
		check(err, 3'h0);
		wait_ms(300);
		check(err, tmg_pkg::LATE_INTERRUPTION_LOCKOUT);
		check(outs, 1'h0);
		ctl(3'h0);
		press(200);
		check(err, 3'h0);
		ctl(3'h1);
		field <= 1'h1;
		wait_ms(20);
		field <= 1'h0;
		wait_ms(19000);
		check(err, 3'h0);
		wait_ms(1200);
		check(err, tmg_pkg::LATE_RELEASE_LOCKOUT);
		ctl(3'h0);
		press(200);
		check(err, 3'h0);
	endtask : lockout_test
	task automatic stop_test();
		mode <= tmg_pkg::QUALIFIED_STOP_MODE;
		ctl(3'h2);
		ctl(3'h3);
		check(act, 1'h1);
		field <= 1'h1;
		wait_ms(20);
		ctl(3'h7);
		check(act, 1'h0);
		check(restart, 1'h1);
		ctl(3'h3);
		check(act, 1'h1);
		field <= 1'h0;
		ctl(3'h0);
		wait_ms(200);
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge core_clk);
		reg_test();
		off_mode_test();
		fast_test();
		gate_low_test();
		lockout_test();
		stop_test();
		summarize();
	end
	// watchdog: well past the longest expected run
	initial begin
		#500_000;
		fail_count++;
		summarize();
	end
endmodule : tb_timed_material_gating

/* bench/tmg_asserts.sv */
/*
 checker beside the gating link: watches the link and the sequencer pins.
 assumes one core clock, async low reset, tick length given by parameter.
*/
`timescale 1ns/1ps
module tmg_asserts #(
	parameter int unsigned TICK_CYCLES = 2
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic gate_request,
	input wire logic timeout_hold,
	input wire logic gating_active,
	input wire logic [2:0] MODE_SEL,
	input wire logic FIELD_INTERRUPTED,
	input wire logic SYNC_A_BLOCKED,
	input wire logic SYNC_B_BLOCKED,
	input wire logic SAFETY_SWITCH_OUTPUTS,
	input wire logic [2:0] ERROR_CODE,
	input wire logic RESTART_REQUIRED,
	input wire logic OVERRIDE_REQUIRED
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////////////////
	// slack covers tick phase and register stages on both ends
	localparam int unsigned SLACK = 3 * TICK_CYCLES + 8;
	localparam int unsigned LOW_MAX = tmg_pkg::GATE_LOW_MS * TICK_CYCLES + SLACK;
	localparam int unsigned IDLE_MAX = tmg_pkg::BOTH_IDLE_MS * TICK_CYCLES + SLACK;
	localparam int unsigned WAIT_MAX = tmg_pkg::LATE_FIELD_MS * TICK_CYCLES + SLACK;
	localparam int unsigned LATE_MIN = (tmg_pkg::LATE_FIELD_MS - 1) * TICK_CYCLES;
	localparam int unsigned REL_MIN = (tmg_pkg::RELEASE_MS - 1) * TICK_CYCLES;
	int unsigned low_reg, low_next; // cycles with request low
	int unsigned idle_reg, idle_next; // cycles with request and field idle
	int unsigned clr_reg, clr_next; // cycles with field clear
	int unsigned wait_reg, wait_next; // cycles bridging with field clear
	////////////////////////////////////////////////////////////////////////
	// run lengths; counters are wide enough for one whole run
	always_comb begin
		low_next = gate_request ? 0 : low_reg + 1;
		idle_next = (gate_request || FIELD_INTERRUPTED) ? 0 : idle_reg + 1;
		clr_next = FIELD_INTERRUPTED ? 0 : clr_reg + 1;
		wait_next = (gating_active && !FIELD_INTERRUPTED) ? wait_reg + 1 : 0;
	end
	// registers only
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			low_reg <= 0;
			idle_reg <= 0;
			clr_reg <= 0;
			wait_reg <= 0;
		end else begin
			low_reg <= low_next;
			idle_reg <= idle_next;
			clr_reg <= clr_next;
			wait_reg <= wait_next;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// mode outside the two gating modes for three samples
	sequence seq_mode_off;
		(MODE_SEL != tmg_pkg::QUALIFIED_STOP_MODE && MODE_SEL != tmg_pkg::FAST_CONVEYOR_MODE) [*3];
	endsequence
	// field held interrupted three samples, outputs on at the third
	sequence seq_dark_field;
		FIELD_INTERRUPTED [*3] ##0 SAFETY_SWITCH_OUTPUTS;
	endsequence
	a_mode_off: assert property (seq_mode_off |-> !gating_active)
		else $error("bridging outside a gating mode");
	a_gate_low: assert property (low_reg > LOW_MAX |-> !gating_active)
		else $error("bridging after long request drop");
	a_both_idle: assert property (idle_reg > IDLE_MAX |-> !gating_active)
		else $error("bridging with field and request idle");
	a_field_wait: assert property (wait_reg > WAIT_MAX |-> !gating_active)
		else $error("bridging with clear field too long");
	a_dark_field: assert property (seq_dark_field |->
		##[0:1] (gating_active || $past(gating_active) || $past(gating_active, 2)))
		else $error("outputs on with field interrupted");
	a_late_err: assert property ($changed(ERROR_CODE) &&
		ERROR_CODE == tmg_pkg::LATE_INTERRUPTION_LOCKOUT |-> clr_reg >= LATE_MIN)
		else $error("late interruption flagged too early");
	a_release_err: assert property ($changed(ERROR_CODE) &&
		ERROR_CODE == tmg_pkg::LATE_RELEASE_LOCKOUT |-> clr_reg >= REL_MIN)
		else $error("late release flagged too early");
	a_lockout_dark: assert property ((ERROR_CODE == tmg_pkg::LATE_INTERRUPTION_LOCKOUT ||
		ERROR_CODE == tmg_pkg::LATE_RELEASE_LOCKOUT) [*2] |->
		!SAFETY_SWITCH_OUTPUTS && !gating_active)
		else $error("outputs on in lockout");
	a_restart_cond: assert property ((!gate_request || (MODE_SEL ==
		tmg_pkg::QUALIFIED_STOP_MODE && !timeout_hold)) [*3] |-> !RESTART_REQUIRED)
		else $error("restart flagged without request");
	a_override_cond: assert property ((!(SYNC_A_BLOCKED && SYNC_B_BLOCKED)) [*3] |->
		!OVERRIDE_REQUIRED)
		else $error("override flagged with a beam clear");
endmodule : tmg_asserts

/* core/tmg_gate_ctl.sv */
/*
 gating controller end: software sets the request through an
 AXI4-Lite register, this end drives request and hold onto the link.
 assumes an AXI4-Lite master on CORE_CLK, RST_B async low.
*/
`timescale 1ns/1ps
module tmg_gate_ctl (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	tmg_link_if.ctl LINK,
	input wire logic [3:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [3:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	////////////////////////////////////////////////////////////////////
	// state
	logic [2:0] ctrl_reg, ctrl_next; // gate, hold used, extend
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [3:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic gate_reg, gate_next, hold_reg, hold_next;

	////////////////////////////////////////////////////////////////////
	// bus slave and link drive
	always_comb begin
		ctrl_next = ctrl_reg;
		// latch address and data independently
		aw_have_next = aw_have_reg | (S_AXI_AWVALID & awready_reg);
		w_have_next = w_have_reg | (S_AXI_WVALID & wready_reg);
		awaddr_next = (S_AXI_AWVALID & awready_reg) ? S_AXI_AWADDR : awaddr_reg;
		wdata_next = (S_AXI_WVALID & wready_reg) ? S_AXI_WDATA : wdata_reg;
		wstrb0_next = (S_AXI_WVALID & wready_reg) ? S_AXI_WSTRB[0] : wstrb0_reg;
		bvalid_next = bvalid_reg & ~S_AXI_BREADY;
		bresp_next = bresp_reg;
		// commit once both halves held and no answer pending
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = tmg_pkg::RESP_OKAY;
			if (awaddr_reg == tmg_pkg::CTRL_OFS) begin
				if (wstrb0_reg) begin
					ctrl_next = wdata_reg[2:0];
				end
			end else if (awaddr_reg != tmg_pkg::STAT_OFS) begin
				bresp_next = tmg_pkg::RESP_SLVERR; // unmapped
			end
		end
		awready_next = ~aw_have_next;
		wready_next = ~w_have_next;
		// reads answer one cycle after the address
		rvalid_next = rvalid_reg & ~S_AXI_RREADY;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (S_AXI_ARVALID && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = tmg_pkg::RESP_OKAY;
			case (S_AXI_ARADDR)
				tmg_pkg::CTRL_OFS: begin
					rdata_next = {29'h0000_0000, ctrl_reg};
				end
				tmg_pkg::STAT_OFS: begin
					rdata_next = {29'h0000_0000, LINK.gating_active, hold_reg, gate_reg};
				end
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = tmg_pkg::RESP_SLVERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;
		// with hold used and extend clear, request and hold flip together: antivalent start and stop
		gate_next = ctrl_reg[tmg_pkg::CTRL_GATE_BIT]; // R03 R06
		hold_next = ctrl_reg[tmg_pkg::CTRL_HOLD_USED_BIT]
			& (~ctrl_reg[tmg_pkg::CTRL_GATE_BIT] | ctrl_reg[tmg_pkg::CTRL_EXTEND_BIT]); // R08 R10 R11 R18
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg <= tmg_pkg::CTRL_RESET;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb0_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
			gate_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			gate_reg <= gate_next;
			hold_reg <= hold_next;
		end
	end

	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign LINK.gate_request = gate_reg;
	assign LINK.timeout_hold = hold_reg;
endmodule : tmg_gate_ctl

/* core/tmg_gate_dev.sv */
/*
 gating sequencer of the light curtain receiver: bridges the safety
 switch outputs while material passes the field.
 assumes synchronous inputs, CORE_CLK at 200 MHz, RST_B async low.
*/
`timescale 1ns/1ps
// Operation
// (R01) gating only in mode 1 or 5
// (R02) field clear beyond clearance tolerance ends gating
// (R03) gate request low over 4 s ends
// (R04) field and request inactive 0.1 s ends; code checks it in ST_GATING only, ST_ARMED keeps bridging until R03, R07 or R15
// (R05) mode 1 clearance tolerance is 2 s
// (R06) mode 1 start by antivalent request/hold change
// (R07) mode 1 no interruption in 4 s: qualified stop
// (R08) mode 1 paired edge change stops, restarts
// (R09) mode 5 tolerates 1 s field clear
// (R10) timeout 10 min, hold extends 100 h
// (R11) unused hold input tied low
// (R12) interrupted field plus request needs restart
// (R13) restart by button press 0.15 to 4 s
// (R14) blocked sync beams need override, not restart
// (R15) no interruption within 4 s: lockout
// (R16) timeout ends gating, outputs off, error
// (R17) request must drop 20 s after clear
// (R18) hold swaps within 0.5 s else lockout
// (R19) outside gating, interruption switches outputs off
// (R20) intervals timed by clock-driven counters
module tmg_gate_dev #(
	parameter int unsigned TICK_CYCLES = tmg_pkg::TICK_CYCLES
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	tmg_link_if.dev LINK,
	input wire logic [2:0] MODE_SEL,
	input wire logic FIELD_INTERRUPTED,
	input wire logic SYNC_A_BLOCKED,
	input wire logic SYNC_B_BLOCKED,
	input wire logic RESET_BUTTON,
	output logic SAFETY_SWITCH_OUTPUTS,
	output logic [2:0] ERROR_CODE,
	output logic RESTART_REQUIRED,
	output logic OVERRIDE_REQUIRED
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int MW = 15; // short intervals, up to 20 s
	localparam int LW = 29; // timeout, up to 100 h
	localparam logic [MW-1:0] MS_MAX = {MW{1'b1}};
	localparam logic [LW-1:0] LONG_MAX = {LW{1'b1}};

	////////////////////////////////////////////////////////////////////
	// state
	logic [TW-1:0] tick_cnt_reg, tick_cnt_next; // ms divider
	logic tick;
	tmg_pkg::tmg_state_t state_reg, state_next;
	tmg_pkg::tmg_err_t err_reg, err_next;
	logic [MW-1:0] st_ms_reg, st_ms_next; // time in state
	logic [MW-1:0] low_ms_reg, low_ms_next; // request low
	logic [MW-1:0] clr_ms_reg, clr_ms_next; // field clear
	logic [MW-1:0] idle_ms_reg, idle_ms_next; // both inactive
	logic [MW-1:0] swap_ms_reg, swap_ms_next; // hold swap wait
	logic [MW-1:0] btn_ms_reg, btn_ms_next; // button held
	logic [LW-1:0] to_ms_reg, to_ms_next; // gating timeout
	logic swap_pend_reg, swap_pend_next;
	logic gate_d_reg, hold_d_reg, btn_d_reg;
	logic ssw_reg, ssw_next;
	logic rst_req_reg, rst_req_next;
	logic ovr_req_reg, ovr_req_next;
	logic act_reg, act_next;

	// saturating millisecond step
	function automatic logic [MW-1:0] step(input logic [MW-1:0] v, input logic en);
		step = (en && v != MS_MAX) ? v + 1'b1 : v;
	endfunction : step

	////////////////////////////////////////////////////////////////////
	// combinational sequencing
	logic gate, hold, qs, mode_ok, req_on, field, btn_ok;
	logic gate_rise, hold_rise, hold_fall;
	logic [MW-1:0] clear_lim;
	logic [LW-1:0] to_lim;

	always_comb begin
		gate = LINK.gate_request;
		hold = LINK.timeout_hold;
		field = FIELD_INTERRUPTED;
		qs = (MODE_SEL == tmg_pkg::QUALIFIED_STOP_MODE);
		mode_ok = qs || (MODE_SEL == tmg_pkg::FAST_CONVEYOR_MODE); // R01
		req_on = qs ? (gate & hold) : gate; // R12
		gate_rise = gate & ~gate_d_reg;
		hold_rise = hold & ~hold_d_reg;
		hold_fall = ~hold & hold_d_reg;
		// clearance tolerance per mode
		clear_lim = qs ? MW'(tmg_pkg::CLEAR_QS_MS) : MW'(tmg_pkg::CLEAR_FAST_MS); // R05 R09
		// hold high stretches the timeout
		to_lim = hold ? LW'(tmg_pkg::TIMEOUT_EXT_MS) : LW'(tmg_pkg::TIMEOUT_MS); // R10
		// ms divider, one-cycle tick
		tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
		tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1; // R20
		// button released inside its window
		btn_ok = btn_d_reg & ~RESET_BUTTON
			& (btn_ms_reg >= MW'(tmg_pkg::BTN_MIN_MS))
			& (btn_ms_reg <= MW'(tmg_pkg::BTN_MAX_MS)); // R13
		btn_ms_next = RESET_BUTTON ? step(btn_d_reg ? btn_ms_reg : '0, tick) : '0;
		state_next = state_reg;
		err_next = err_reg;
		swap_pend_next = swap_pend_reg & hold; // swap done once hold drops
		rst_req_next = 1'b0;
		ovr_req_next = 1'b0;
		case (state_reg)
			tmg_pkg::ST_IDLE,
			tmg_pkg::ST_STOPPED: begin
				// restart or override demand while request is on
				if (field && req_on) begin
					if (SYNC_A_BLOCKED && SYNC_B_BLOCKED) begin
						ovr_req_next = 1'b1; // R14
					end else begin
						rst_req_next = 1'b1; // R12
						if (btn_ok) begin
							state_next = tmg_pkg::ST_GATING; // R13
						end
					end
				end else if (state_reg == tmg_pkg::ST_IDLE && gate_rise) begin
					state_next = tmg_pkg::ST_ARMED; // R06
					swap_pend_next = qs & hold_d_reg & hold; // R18
				end else if (state_reg == tmg_pkg::ST_STOPPED) begin
					if (qs && gate && hold_fall) begin
						state_next = tmg_pkg::ST_ARMED; // R08
					end else if (!gate && low_ms_reg > MW'(tmg_pkg::GATE_LOW_MS)) begin
						state_next = tmg_pkg::ST_IDLE; // R03
					end
				end
			end
			tmg_pkg::ST_ARMED: begin
				if (swap_pend_reg && swap_ms_reg > MW'(tmg_pkg::SWAP_MS)) begin
					state_next = tmg_pkg::ST_LOCKOUT;
					err_next = tmg_pkg::FAULTY_CONTROL_LOCKOUT; // R18
				end else if (!gate && low_ms_reg > MW'(tmg_pkg::GATE_LOW_MS)) begin
					state_next = tmg_pkg::ST_IDLE; // R03
				end else if (qs && gate && hold_rise) begin
					state_next = tmg_pkg::ST_STOPPED; // R08
				end else if (field) begin
					state_next = tmg_pkg::ST_GATING;
				end else if (st_ms_reg > MW'(tmg_pkg::LATE_FIELD_MS)) begin
					if (qs) begin
						state_next = tmg_pkg::ST_STOPPED; // R07
					end else begin
						state_next = tmg_pkg::ST_LOCKOUT;
						err_next = tmg_pkg::LATE_INTERRUPTION_LOCKOUT; // R15
					end
				end
			end
			tmg_pkg::ST_GATING: begin
				if (to_ms_reg > to_lim) begin
					state_next = tmg_pkg::ST_LOCKOUT;
					err_next = tmg_pkg::GATING_TIMEOUT_ERROR; // R16
				end else if (swap_pend_reg && swap_ms_reg > MW'(tmg_pkg::SWAP_MS)) begin
					state_next = tmg_pkg::ST_LOCKOUT;
					err_next = tmg_pkg::FAULTY_CONTROL_LOCKOUT; // R18
				end else if (low_ms_reg > MW'(tmg_pkg::GATE_LOW_MS)) begin
					state_next = tmg_pkg::ST_IDLE; // R03
				end else if (idle_ms_reg > MW'(tmg_pkg::BOTH_IDLE_MS)) begin
					state_next = tmg_pkg::ST_IDLE; // R04
				end else if (clr_ms_reg > clear_lim) begin
					state_next = tmg_pkg::ST_CLEARED; // R02
				end else if (qs && gate && hold_rise) begin
					state_next = tmg_pkg::ST_STOPPED; // R08
				end
			end
			tmg_pkg::ST_CLEARED: begin
				// gating over; request must now fall
				if (!gate) begin
					state_next = tmg_pkg::ST_IDLE;
				end else if (clr_ms_reg > MW'(tmg_pkg::RELEASE_MS)) begin
					state_next = tmg_pkg::ST_LOCKOUT;
					err_next = tmg_pkg::LATE_RELEASE_LOCKOUT; // R17
				end
			end
			tmg_pkg::ST_LOCKOUT: begin
				// button acknowledges the lockout
				if (btn_ok) begin
					state_next = tmg_pkg::ST_IDLE;
					err_next = tmg_pkg::ERR_NONE;
				end
			end
			default: begin
				state_next = tmg_pkg::ST_LOCKOUT;
			end
		endcase
		// outside modes 1 and 5 nothing is bridged
		if (!mode_ok && state_reg != tmg_pkg::ST_LOCKOUT) begin
			state_next = tmg_pkg::ST_IDLE; // R01
		end
		// interval counters, all on the ms tick
		st_ms_next = (state_next != state_reg) ? '0 : step(st_ms_reg, tick); // R20
		low_ms_next = gate ? '0 : step(low_ms_reg, tick);
		clr_ms_next = field ? '0 : step(clr_ms_reg, tick);
		idle_ms_next = (field | gate) ? '0 : step(idle_ms_reg, tick);
		swap_ms_next = swap_pend_next ? step(swap_ms_reg, tick) : '0;
		to_ms_next = (state_reg != tmg_pkg::ST_GATING) ? '0 :
			((tick && to_ms_reg != LONG_MAX) ? to_ms_reg + 1'b1 : to_ms_reg);
		// bridge while armed or gating, else follow the field; lockout keeps outputs off
		act_next = (state_next == tmg_pkg::ST_ARMED) || (state_next == tmg_pkg::ST_GATING);
		ssw_next = (state_next != tmg_pkg::ST_LOCKOUT) && (act_next || !field); // R19
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt_reg <= '0;
			state_reg <= tmg_pkg::ST_IDLE;
			err_reg <= tmg_pkg::ERR_NONE;
			st_ms_reg <= '0;
			low_ms_reg <= '0;
			clr_ms_reg <= '0;
			idle_ms_reg <= '0;
			swap_ms_reg <= '0;
			btn_ms_reg <= '0;
			to_ms_reg <= '0;
			swap_pend_reg <= 1'b0;
			gate_d_reg <= 1'b0;
			hold_d_reg <= 1'b0;
			btn_d_reg <= 1'b0;
			ssw_reg <= 1'b0;
			rst_req_reg <= 1'b0;
			ovr_req_reg <= 1'b0;
			act_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			state_reg <= state_next;
			err_reg <= err_next;
			st_ms_reg <= st_ms_next;
			low_ms_reg <= low_ms_next;
			clr_ms_reg <= clr_ms_next;
			idle_ms_reg <= idle_ms_next;
			swap_ms_reg <= swap_ms_next;
			btn_ms_reg <= btn_ms_next;
			to_ms_reg <= to_ms_next;
			swap_pend_reg <= swap_pend_next;
			gate_d_reg <= gate;
			hold_d_reg <= hold;
			btn_d_reg <= RESET_BUTTON;
			ssw_reg <= ssw_next;
			rst_req_reg <= rst_req_next;
			ovr_req_reg <= ovr_req_next;
			act_reg <= act_next;
		end
	end

	// outputs straight from flip-flops
	assign SAFETY_SWITCH_OUTPUTS = ssw_reg;
	assign ERROR_CODE = err_reg;
	assign RESTART_REQUIRED = rst_req_reg;
	assign OVERRIDE_REQUIRED = ovr_req_reg;
	assign LINK.gating_active = act_reg;
endmodule : tmg_gate_dev

/* core/tmg_link_if.sv */
/*
 link between the gating controller and the gating sequencer.
 assumes both ends share the core clock; the bench ties them.
*/
`timescale 1ns/1ps
interface tmg_link_if;
	logic gate_request; // controller asks for bridging
	logic timeout_hold; // controller holds or extends timeout
	logic gating_active; // sequencer reports bridging
	// sequencer end
	modport dev (input gate_request, input timeout_hold, output gating_active);
	// controller end
	modport ctl (output gate_request, output timeout_hold, input gating_active);
endinterface : tmg_link_if

/* core/tmg_pkg.sv */
/*
 package for the timed material gating pair: timing figures, modes,
 states, lockout codes and the controller's register map.
 assumes a single 200 MHz core clock and a 1 ms timing tick.
*/
package tmg_pkg;
	// clock and timing tick
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TICK_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// interval limits in milliseconds
	localparam int unsigned CLEAR_QS_MS = 2000;
	localparam int unsigned CLEAR_FAST_MS = 1000;
	localparam int unsigned GATE_LOW_MS = 4000;
	localparam int unsigned BOTH_IDLE_MS = 100;
	localparam int unsigned SWAP_MS = 500;
	localparam int unsigned LATE_FIELD_MS = 4000;
	localparam int unsigned RELEASE_MS = 20_000;
	localparam int unsigned BTN_MIN_MS = 150;
	localparam int unsigned BTN_MAX_MS = 4000;
	// default timeout 10 min, extended 100 h
	localparam int unsigned TIMEOUT_MS = 10 * 60 * 1000;
	localparam int unsigned TIMEOUT_EXT_MS = 100 * 3600 * 1000;
	// operating mode selector codes
	localparam logic [2:0] QUALIFIED_STOP_MODE = 3'h1;
	localparam logic [2:0] FAST_CONVEYOR_MODE = 3'h5;
	// sequencer states, gray along idle-armed-gating-cleared
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ARMED = 3'h1,
		ST_GATING = 3'h3,
		ST_CLEARED = 3'h2,
		ST_STOPPED = 3'h6,
		ST_LOCKOUT = 3'h7
	} tmg_state_t;
	// lockout and error codes
	typedef enum logic [2:0] {
		ERR_NONE = 3'h0,
		LATE_INTERRUPTION_LOCKOUT = 3'h1,
		GATING_TIMEOUT_ERROR = 3'h2,
		LATE_RELEASE_LOCKOUT = 3'h3,
		FAULTY_CONTROL_LOCKOUT = 3'h4
	} tmg_err_t;
	// controller register map and fields
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int unsigned CTRL_GATE_BIT = 0;
	localparam int unsigned CTRL_HOLD_USED_BIT = 1;
	localparam int unsigned CTRL_EXTEND_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmg_pkg
